/* File: shared/arm_pkg.sv */
package arm_pkg;
   // port offsets within the audio block (low nibble of 2xNh)
   localparam logic [3:0]  PORT_RESET      = 4'h6;
   localparam logic [3:0]  PORT_READ_DATA  = 4'hA;
   localparam logic [3:0]  PORT_RD_STATUS  = 4'hE;
   // extra local ports for mode, mixer index/data, mute control
   localparam logic [3:0]  PORT_MODE       = 4'h8;
   localparam logic [3:0]  PORT_MIX_ADDR   = 4'h4;
   localparam logic [3:0]  PORT_MIX_DATA   = 4'h5;
   localparam logic [3:0]  PORT_MUTE_CTL   = 4'h7;
   // field positions
   localparam int          BIT_SW_RESET    = 0;
   localparam int          BIT_RD_AVAIL    = 7;
   localparam int          BIT_EXT_MODE    = 0;
   localparam int          BIT_TB_SEL      = 1;
   localparam int          BIT_MUTE_PWRUP  = 0;
   localparam int          BIT_PWR_DOWN    = 1;
   // reset values
   localparam logic [7:0]  RESET_ACK       = 8'hAA;
   localparam logic [7:0]  DAC_MID         = 8'h80;
   localparam logic [7:0]  VOL_MAX         = 8'hFF;
   localparam logic [7:0]  VOL_MID         = 8'h80;
   localparam logic [7:0]  MIX_DEFAULT     = 8'h00;
   localparam logic [7:0]  MIX_ID_REG      = 8'h40;
   // identity bytes: values arbitrary
   localparam logic [7:0]  ID_BYTE0        = 8'h5A;
   localparam logic [7:0]  ID_BYTE1        = 8'hC3;
   localparam logic [11:0] CFG_BASE        = 12'h0000;
   // dma counts and fifo sizes in bytes
   localparam logic [15:0] DMA_RESET_LEN   = 16'h0800;
   localparam int          COMPAT_FIFO_LEN = 64;
   localparam int          EXT_FIFO_LEN    = 256;
   // sample rate and timer bases, hz
   localparam int          RESET_RATE_HZ   = 8000;
   localparam int          TB_COMPAT_0_HZ  = 1000000;
   localparam int          TB_COMPAT_1_HZ  = 1500000;
   localparam int          TB_EXT_0_HZ     = 800000;
   localparam int          TB_EXT_1_HZ     = 400000;
   localparam logic [7:0]  DIV_8K_COMPAT   =
      8'(256 - TB_COMPAT_0_HZ / RESET_RATE_HZ);
   localparam logic [7:0]  FILT_8K         = 8'h00;
   // timing: clock, mute settle delay, host poll time
   localparam int          CLK_HZ          = 100000000;
   localparam int          MUTE_DELAY_MS   = 133;
   localparam int          POLL_MIN_MS     = 1;
   localparam int          MUTE_DELAY_CYC  =
      MUTE_DELAY_MS * (CLK_HZ / 1000);
   localparam int          POLL_MIN_CYC    =
      POLL_MIN_MS * (CLK_HZ / 1000);
   localparam int          SW_RST_HOLD_CYC = 4;

   // number of fifo bytes usable in a mode
   function automatic int arm_fifo_len(input logic ext);
      arm_fifo_len = ext ? EXT_FIFO_LEN : COMPAT_FIFO_LEN;
   endfunction : arm_fifo_len
endpackage : arm_pkg

/* File: shared/arm_bus_if.sv */
`timescale 1ns/1ps
// host-to-device port bus: one access per strobe, read data next cycle
interface arm_bus_if;
   logic       bus_reset;  // host bus reset, high
   logic [3:0] addr;       // port offset
   logic [7:0] wdata;      // write byte
   logic       wr;         // write strobe, one cycle
   logic       rd;         // read strobe, one cycle
   logic [7:0] rdata;      // read byte
   logic       rvalid;     // read answer, one cycle
   logic       amp_mute;   // amplifier mute, low = muted

   modport dev  (input bus_reset, addr, wdata, wr, rd,
                 output rdata, rvalid, amp_mute);
   modport host (output bus_reset, addr, wdata, wr, rd,
                 input rdata, rvalid, amp_mute);
endinterface : arm_bus_if

/* File: core/arm_mute_delay.sv */
`timescale 1ns/1ps
// mute output with settle delay on power-up
module arm_mute_delay
   import arm_pkg::*;
#(
   parameter int DELAY_CYC = MUTE_DELAY_CYC
) (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // control
   input  wire logic want_high_i,
   // output
   output logic      mute_o
);
   typedef struct packed {
      logic [27:0] cnt;   // settle counter
      logic        mute;  // output level
   } arm_md_type;
   arm_md_type s_q, s_d;

   // count while high is wanted, raise after delay
   always_comb begin
      s_d = s_q;
      if (!want_high_i) begin
         s_d.cnt  = '0;
         s_d.mute = 1'b0;  // low in power-down [R19]
      end else if (s_q.cnt >= 28'(DELAY_CYC - 1)) begin
         s_d.mute = 1'b1;  // only after settle time [R20]
      end else begin
         s_d.cnt = s_q.cnt + 28'd1;
      end
   end

   // state register, low after reset [R19]
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign mute_o = s_q.mute;
endmodule : arm_mute_delay

/* File: core/arm_device.sv */
`timescale 1ns/1ps
// Operation
// R1 - bus reset does full reset
// R2 - bit 0 of reset port soft resets
// R3 - host writes 1, waits, writes 0
// R4 - host polls status bit 7, reads data
// R5 - on completion flag data, present 0AAh
// R6 - reset clears extended mode, dma, irq
// R7 - reset loads 8 kHz timer and filter
// R8 - reset loads both dma counts 2048
// R9 - reset: dac direction, mid-scale value
// R10 - reset mutes voice until re-enabled
// R11 - reset: agc 8-bit volume maximum
// R12 - reset: 16-bit volume mid-range
// R13 - only hardware reset clears mixer
// R14 - id register gives four bytes
// R15 - compatibility mode after every reset
// R16 - compat: hw fifo off, 64 bytes
// R17 - extended: 256-byte hardware fifo
// R18 - timer base depends on mode
// R19 - mute low after reset, sw controlled
// R20 - mute rises after 133 ms delay
// R21 - synth state static under clock stop
// R22 - hold reset while bit set
module arm_device
   import arm_pkg::*;
#(
   parameter int MUTE_CYC = MUTE_DELAY_CYC
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // host bus
   arm_bus_if.dev           bus,
   // user side status
   input  wire logic        voice_on_i,    // voice enable command
   input  wire logic        adc_dir_i,     // adc direction command
   output logic             ext_mode_o,
   output logic             dma_active_o,
   output logic             irq_o,
   output logic             voice_on_o,
   output logic             adc_dir_o,
   output logic [7:0]       dac_value_o,
   output logic [7:0]       timer_div_o,
   output logic [7:0]       filter_o,
   output logic [15:0]      dma_cnt_compat_o,
   output logic [15:0]      dma_cnt_ext_o,
   output logic [7:0]       agc_vol_o,
   output logic [7:0]       rec16_vol_o,
   output logic [8:0]       fifo_len_o,
   output logic [20:0]      timer_base_hz_o
);
   typedef struct packed {
      logic        sw_rst;      // soft reset bit
      logic        rd_avail;    // read data available
      logic [7:0]  rd_data;     // read data port
      logic        ext;         // extended mode
      logic        tb_sel;      // time base select
      logic        dma;         // dma running
      logic        irq;         // irq pending
      logic        voice;       // voice path enabled
      logic        adc;         // adc direction
      logic [7:0]  dac;         // dac level
      logic [7:0]  div;         // timer divider
      logic [7:0]  filt;        // filter setting
      logic [15:0] cnt_c;       // compat dma count
      logic [15:0] cnt_e;       // ext dma count
      logic [7:0]  auto_gain_control;         // agc input volume
      logic [7:0]  v16;         // 16-bit input volume
      logic [7:0]  mix_addr;    // mixer index
      logic [7:0]  mix_data;    // one mixer register
      logic [1:0]  id_ptr;      // id read position
      logic        mute_want;   // sw wants mute high
      logic [7:0]  rdata;       // bus read answer
      logic        rvalid;      // read answer strobe
   } arm_dev_type;
   arm_dev_type s_q, s_d;
   logic mute_w;  // delayed mute level

   // soft reset defaults; the bus reset loads these too, with rd_avail set and the ack byte
   function automatic arm_dev_type common_reset(input arm_dev_type s);
      arm_dev_type r;
      r          = s;
      r.ext      = 1'b0;            // [R6] [R15]
      r.dma      = 1'b0;            // [R6]
      r.irq      = 1'b0;            // [R6]
      r.div      = DIV_8K_COMPAT;   // [R7]
      r.filt     = FILT_8K;         // [R7]
      r.tb_sel   = 1'b0;            // divider assumes 1 MHz base [R7]
      r.cnt_c    = DMA_RESET_LEN;   // [R8]
      r.cnt_e    = DMA_RESET_LEN;   // [R8]
      r.adc      = 1'b0;            // [R9]
      r.dac      = DAC_MID;         // [R9]
      r.voice    = 1'b0;            // [R10]
      r.auto_gain_control      = VOL_MAX;         // [R11]
      r.v16      = VOL_MID;         // [R12]
      r.id_ptr   = 2'd0;
      r.rd_avail = 1'b0;
      common_reset = r;
   endfunction : common_reset

   // id byte by position
   function automatic logic [7:0] id_byte(input logic [1:0] p);
      unique case (p)
         2'd0: id_byte = ID_BYTE0;
         2'd1: id_byte = ID_BYTE1;
         2'd2: id_byte = {4'h0, CFG_BASE[11:8]};
         2'd3: id_byte = CFG_BASE[7:0];
      endcase
   endfunction : id_byte

   // next state: bus decode and reset sequencing
   always_comb begin
      s_d        = s_q;
      if (s_q.sw_rst) begin
         s_d = common_reset(s_q);  // held while bit set [R22]
      end
      s_d.rvalid = 1'b0;  // after the reset copy, so no strobe replays
      // user commands, only out of soft reset
      if (!s_q.sw_rst) begin
         if (voice_on_i) s_d.voice = 1'b1;  // re-enable by command [R10]
         if (adc_dir_i)  s_d.adc   = 1'b1;
      end
      if (bus.wr) begin
         unique case (bus.addr)
            PORT_RESET: begin
               s_d.sw_rst = bus.wdata[BIT_SW_RESET];  // [R2]
               if (s_q.sw_rst && !bus.wdata[BIT_SW_RESET]) begin
                  // release: finish with ack byte [R5] [R22]
                  s_d          = common_reset(s_d);
                  s_d.rd_avail = 1'b1;
                  s_d.rd_data  = RESET_ACK;
               end else if (bus.wdata[BIT_SW_RESET]) begin
                  s_d = common_reset(s_d);  // [R2]
               end
            end
            PORT_MODE: begin
               if (!s_q.sw_rst) begin
                  s_d.ext    = bus.wdata[BIT_EXT_MODE];
                  s_d.tb_sel = bus.wdata[BIT_TB_SEL];
               end
            end
            PORT_MIX_ADDR: begin
               s_d.mix_addr = bus.wdata;
               s_d.id_ptr   = 2'd0;  // new index restarts id
            end
            PORT_MIX_DATA: begin
               // mixer kept across soft reset [R13]
               if (s_q.mix_addr != MIX_ID_REG) s_d.mix_data = bus.wdata;
            end
            PORT_MUTE_CTL: begin
               // powered up and not powered down [R19]
               s_d.mute_want = bus.wdata[BIT_MUTE_PWRUP] &
                               ~bus.wdata[BIT_PWR_DOWN];
            end
            default: begin
            end
         endcase
      end
      if (bus.rd) begin
         s_d.rvalid = 1'b1;
         unique case (bus.addr)
            PORT_RESET:     s_d.rdata = {7'h00, s_q.sw_rst};
            PORT_RD_STATUS: s_d.rdata = {s_q.rd_avail, 7'h00};  // [R4]
            PORT_READ_DATA: begin
               s_d.rdata    = s_q.rd_data;
               s_d.rd_avail = 1'b0;
            end
            PORT_MODE:      s_d.rdata = {6'h00, s_q.tb_sel, s_q.ext};
            PORT_MIX_ADDR:  s_d.rdata = s_q.mix_addr;
            PORT_MIX_DATA: begin
               if (s_q.mix_addr == MIX_ID_REG) begin
                  s_d.rdata  = id_byte(s_q.id_ptr);  // [R14]
                  s_d.id_ptr = s_q.id_ptr + 2'd1;
               end else begin
                  s_d.rdata = s_q.mix_data;
               end
            end
            default:        s_d.rdata = 8'h00;
         endcase
      end
   end

   // state register; bus reset clears mixer too [R1] [R13]
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || bus.bus_reset) begin
         s_q          <= '0;
         s_q.div      <= DIV_8K_COMPAT;
         s_q.filt     <= FILT_8K;
         s_q.cnt_c    <= DMA_RESET_LEN;
         s_q.cnt_e    <= DMA_RESET_LEN;
         s_q.dac      <= DAC_MID;
         s_q.auto_gain_control      <= VOL_MAX;
         s_q.v16      <= VOL_MID;
         s_q.mix_data <= MIX_DEFAULT;
         s_q.rd_avail <= 1'b1;       // [R5]
         s_q.rd_data  <= RESET_ACK;  // [R5]
      end else begin
         s_q <= s_d;
      end
   end

   // amplifier mute with settle delay [R19] [R20]
   arm_mute_delay #(.DELAY_CYC(MUTE_CYC)) u_mute (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i | bus.bus_reset),
      .want_high_i (s_q.mute_want),
      .mute_o      (mute_w)
   );

   // registered derived outputs; synth logic is plain static flops [R21]
   logic [8:0]  flen_q;
   logic [20:0] tb_q;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         flen_q <= 9'(COMPAT_FIFO_LEN);
         tb_q   <= 21'(TB_COMPAT_0_HZ);
      end else begin
         flen_q <= 9'(arm_fifo_len(s_q.ext));  // [R16] [R17]
         if (s_q.ext) begin  // [R18]
            tb_q <= s_q.tb_sel ? 21'(TB_EXT_1_HZ) : 21'(TB_EXT_0_HZ);
         end else begin
            tb_q <= s_q.tb_sel ? 21'(TB_COMPAT_1_HZ)
                                : 21'(TB_COMPAT_0_HZ);
         end
      end
   end

   assign bus.rdata        = s_q.rdata;
   assign bus.rvalid       = s_q.rvalid;
   assign bus.amp_mute     = mute_w;
   assign ext_mode_o       = s_q.ext;
   assign dma_active_o     = s_q.dma & s_q.ext;  // hw dma only extended
   assign irq_o            = s_q.irq;
   assign voice_on_o       = s_q.voice;
   assign adc_dir_o        = s_q.adc;
   assign dac_value_o      = s_q.dac;
   assign timer_div_o      = s_q.div;
   assign filter_o         = s_q.filt;
   assign dma_cnt_compat_o = s_q.cnt_c;
   assign dma_cnt_ext_o    = s_q.cnt_e;
   assign agc_vol_o        = s_q.auto_gain_control;
   assign rec16_vol_o      = s_q.v16;
   assign fifo_len_o       = flen_q;
   assign timer_base_hz_o  = tb_q;
endmodule : arm_device

/* File: core/arm_host.sv */
`timescale 1ns/1ps
// host end: runs soft reset sequence and waits for ack
module arm_host
   import arm_pkg::*;
#(
   parameter int POLL_CYC = POLL_MIN_CYC
) (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // bus to device
   arm_bus_if.host   bus,
   // user side
   input  wire logic start_i,   // begin soft reset, pulse
   output logic      busy_o,
   output logic      done_o,    // ack seen, pulse
   output logic      fail_o     // no ack in poll time, pulse
);
   typedef enum logic [5:0] {
      H_IDLE = 6'b00_0001, H_SET  = 6'b00_0010, H_WAIT = 6'b00_0100,
      H_CLR  = 6'b00_1000, H_POLL = 6'b01_0000, H_READ = 6'b10_0000
   } arm_hst_type;
   typedef struct packed {
      arm_hst_type st;
      logic [19:0] cnt;
      logic        rd_pend;
      logic        wr, rd, done, fail;
      logic [3:0]  addr;
      logic [7:0]  wdata;
   } arm_hs_type;
   arm_hs_type s_q, s_d;

   // soft reset sequence and polling
   always_comb begin
      s_d      = s_q;
      s_d.wr   = 1'b0;
      s_d.rd   = 1'b0;
      s_d.done = 1'b0;
      s_d.fail = 1'b0;
      unique case (s_q.st)
         H_IDLE: if (start_i) begin
            s_d.st = H_SET;
         end
         H_SET: begin  // write 1 [R3]
            s_d.wr    = 1'b1;
            s_d.addr  = PORT_RESET;
            s_d.wdata = 8'h01;
            s_d.cnt   = '0;
            s_d.st    = H_WAIT;
         end
         H_WAIT: begin  // short delay by read back [R3]
            s_d.cnt = s_q.cnt + 20'd1;
            if (s_q.cnt == 20'd0) begin
               s_d.rd   = 1'b1;
               s_d.addr = PORT_RESET;
            end
            if (s_q.cnt == 20'(SW_RST_HOLD_CYC)) s_d.st = H_CLR;
         end
         H_CLR: begin  // write 0 [R3]
            s_d.wr    = 1'b1;
            s_d.addr  = PORT_RESET;
            s_d.wdata = 8'h00;
            s_d.cnt   = '0;
            s_d.st    = H_POLL;
         end
         H_POLL: begin  // poll status bit 7 [R4]
            s_d.cnt = s_q.cnt + 20'd1;
            if (!s_q.rd_pend) begin
               s_d.rd      = 1'b1;
               s_d.addr    = PORT_RD_STATUS;
               s_d.rd_pend = 1'b1;
            end else if (bus.rvalid) begin
               s_d.rd_pend = 1'b0;
               if (bus.rdata[BIT_RD_AVAIL]) s_d.st = H_READ;
            end
            if (s_q.cnt >= 20'(POLL_CYC) && !s_q.rd_pend) begin
               s_d.fail = 1'b1;
               s_d.st   = H_IDLE;
            end
         end
         H_READ: begin  // read data, exit on ack [R4]
            if (!s_q.rd_pend) begin
               s_d.rd      = 1'b1;
               s_d.addr    = PORT_READ_DATA;
               s_d.rd_pend = 1'b1;
            end else if (bus.rvalid) begin
               s_d.rd_pend = 1'b0;
               if (bus.rdata == RESET_ACK) begin
                  s_d.done = 1'b1;
                  s_d.st   = H_IDLE;
               end else begin
                  s_d.st = H_POLL;
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q    <= '0;
         s_q.st <= H_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.bus_reset = rst_i;  // host reset drives bus reset [R1]
   assign bus.addr      = s_q.addr;
   assign bus.wdata     = s_q.wdata;
   assign bus.wr        = s_q.wr;
   assign bus.rd        = s_q.rd;
   assign busy_o        = (s_q.st != H_IDLE);
   assign done_o        = s_q.done;
   assign fail_o        = s_q.fail;
endmodule : arm_host

/* File: verif/arm_asserts.sv */
`timescale 1ns/1ps
// watches the port bus between the joined host and device
module arm_asserts
   import arm_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   // bus signals
   input  wire logic       bus_reset,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   input  wire logic       amp_mute
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic       ack_pend_q;  // ack byte owed by the device
   logic       seen_q;      // last read answer was a status with data ready
   logic [3:0] raddr_q;     // offset of the last read

   // ack owed after any reset or a release of soft reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || bus_reset || (wr && addr == PORT_RESET && !wdata[0]))
         ack_pend_q <= 1'b1;
      else if (rd && addr == PORT_READ_DATA)
         ack_pend_q <= 1'b0;
   end

   // where the last read went and what status said
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         raddr_q <= 4'h0;
         seen_q  <= 1'b0;
      end else begin
         if (rd)
            raddr_q <= addr;
         if (rvalid)
            seen_q <= raddr_q == PORT_RD_STATUS && rdata[BIT_RD_AVAIL];
      end
   end

   property p_rd_answer;
      rd |=> rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered next cycle");
   property p_rvalid_cause;
      rvalid |-> $past(rd);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("answer without a read");
   // read byte only moves with an answer; skip the edge after reset
   property p_rdata_hold;
      !rvalid && !$past(rst_i) |-> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read byte moved without an answer");
   property p_ack_status;
      rd && addr == PORT_RD_STATUS && ack_pend_q |=> rdata[BIT_RD_AVAIL];
   endproperty
   a_ack_status: assert property (p_ack_status)
      else $error("status lacks data ready after reset");
   property p_ack_data;
      rd && addr == PORT_READ_DATA && ack_pend_q |=> rdata == RESET_ACK;
   endproperty
   a_ack_data: assert property (p_ack_data)
      else $error("ack byte wrong after reset");
   property p_set_then_clear;
      wr && addr == PORT_RESET && wdata[BIT_SW_RESET] |=>
         ##[0:4] (rd && addr == PORT_RESET)
         ##[1:40] (wr && addr == PORT_RESET && !wdata[BIT_SW_RESET]);
   endproperty
   a_set_then_clear: assert property (p_set_then_clear)
      else $error("soft reset not read back and cleared");
   property p_poll_first;
      rd && addr == PORT_READ_DATA |-> seen_q;
   endproperty
   a_poll_first: assert property (p_poll_first)
      else $error("data read before status showed it ready");
   property p_mute_low;
      $past(rst_i) |-> !amp_mute [*8];
   endproperty
   a_mute_low: assert property (p_mute_low)
      else $error("amplifier not muted after reset");

   // main scenarios reached
   c_set: cover property (wr && addr == PORT_RESET && wdata[0]);
   c_ack: cover property (rd && addr == PORT_READ_DATA && ack_pend_q);
   c_ready: cover property (rvalid && seen_q);
endmodule : arm_asserts

/* File: verif/audio_reset_mode_control_tb.sv */
`timescale 1ns/1ps
// joined host and device, plus a second device driven from here
module audio_reset_mode_control_tb;
   import arm_pkg::*;
   typedef struct {
      string      name;
      logic [7:0] exp;
      logic [7:0] mask;
   } arm_note_type;
   localparam int MUTE_TB = 20;  // short settle delay keeps runs small
   logic        clk, rst, start, busy, done, fail, voice_on, adc_dir;
   logic        ext, dma, irq, von, adir;
   logic [7:0]  dac, div, filt, auto_gain_control, v16, mix;
   logic [15:0] cc, ce;
   logic [8:0]  flen;
   logic [20:0] tbase;
   integer      seed, bad_count, checked, cyc, cnt;
   arm_note_type rq[$];  // expected read answers of device b
   arm_note_type n;      // note being compared
   logic [1:0]  hq[$];   // expected host outcomes {done, fail}
   int          bases[4] = '{TB_COMPAT_0_HZ, TB_EXT_0_HZ,
                             TB_COMPAT_1_HZ, TB_EXT_1_HZ};
   arm_bus_if bus_a();
   arm_bus_if bus_b();

   // pair under test: host end facing device end
   arm_host #(.POLL_CYC(200)) u_arm_host (.sys_clk_i(clk), .rst_i(rst),
      .bus(bus_a), .start_i(start), .busy_o(busy), .done_o(done),
      .fail_o(fail));
   arm_device #(.MUTE_CYC(MUTE_TB)) u_arm_device (.sys_clk_i(clk),
      .rst_i(rst), .bus(bus_a), .voice_on_i(1'b0), .adc_dir_i(1'b0),
      .ext_mode_o(), .dma_active_o(), .irq_o(), .voice_on_o(),
      .adc_dir_o(), .dac_value_o(), .timer_div_o(), .filter_o(),
      .dma_cnt_compat_o(), .dma_cnt_ext_o(), .agc_vol_o(),
      .rec16_vol_o(), .fifo_len_o(), .timer_base_hz_o());
   // second device, its bus driven by the tasks below
   arm_device #(.MUTE_CYC(MUTE_TB)) u_arm_device_b (.sys_clk_i(clk),
      .rst_i(rst), .bus(bus_b), .voice_on_i(voice_on),
      .adc_dir_i(adc_dir), .ext_mode_o(ext), .dma_active_o(dma),
      .irq_o(irq), .voice_on_o(von), .adc_dir_o(adir),
      .dac_value_o(dac), .timer_div_o(div), .filter_o(filt),
      .dma_cnt_compat_o(cc), .dma_cnt_ext_o(ce), .agc_vol_o(auto_gain_control),
      .rec16_vol_o(v16), .fifo_len_o(flen), .timer_base_hz_o(tbase));
   arm_asserts u_arm_asserts (.sys_clk_i(clk), .rst_i(rst),
      .bus_reset(bus_a.bus_reset), .addr(bus_a.addr),
      .wdata(bus_a.wdata), .wr(bus_a.wr), .rd(bus_a.rd),
      .rdata(bus_a.rdata), .rvalid(bus_a.rvalid),
      .amp_mute(bus_a.amp_mute));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop();
      if (bad_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // timeout, then answers taken off the queues as they show up
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         report_and_stop();
      end
      if (bus_b.rvalid === 1'b1) begin
         if (rq.size() == 0)
            chk("unasked read", 1, 0);
         else begin
            n = rq.pop_front();
            chk(n.name, 32'(bus_b.rdata & n.mask), 32'(n.exp & n.mask));
         end
      end
      if ((done | fail) === 1'b1) begin
         if (hq.size() == 0)
            chk("unasked host end", 1, 0);
         else
            chk("host end", 32'({done, fail}), 32'(hq.pop_front()));
      end
   end

   task automatic idle(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : idle

   // one write strobe, data inverted once released
   task automatic wr_b(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      #1;
      bus_b.addr  = a;
      bus_b.wdata = d;
      bus_b.wr    = 1'b1;
      @(posedge clk);
      #1;
      bus_b.wr    = 1'b0;
      bus_b.wdata = ~d;
   endtask : wr_b

   // one read strobe, expected byte noted first
   task automatic rd_b(string what, logic [3:0] a, logic [7:0] e,
                       logic [7:0] m);
      rq.push_back('{what, e, m});
      @(posedge clk);
      #1;
      bus_b.addr = a;
      bus_b.rd   = 1'b1;
      @(posedge clk);
      #1;
      bus_b.rd   = 1'b0;
   endtask : rd_b

   // values every reset must leave on device b
   task automatic chk_defaults();
      chk("ext mode", ext, 0);
      chk("dma active", dma, 0);
      chk("irq", irq, 0);
      chk("voice", von, 0);
      chk("adc dir", adir, 0);
      chk("dac", dac, DAC_MID);
      chk("divider", div, DIV_8K_COMPAT);
      chk("filter", filt, FILT_8K);
      chk("count compat", cc, DMA_RESET_LEN);
      chk("count ext", ce, DMA_RESET_LEN);
      chk("agc vol", auto_gain_control, VOL_MAX);
      chk("vol 16", v16, VOL_MID);
      chk("fifo", flen, COMPAT_FIFO_LEN);
      chk("time base", tbase, TB_COMPAT_0_HZ);
      rd_b("status", PORT_RD_STATUS, 8'h80, 8'h80);
      rd_b("ack", PORT_READ_DATA, RESET_ACK, 8'hFF);
   endtask : chk_defaults

   initial begin
      seed = 16593;
      bad_count = 0;
      checked = 0;
      cyc = 0;
      {rst, bus_b.bus_reset} = 2'b11;
      {start, voice_on, adc_dir, bus_b.wr, bus_b.rd} = 5'h00;
      bus_b.addr = 4'h0;
      bus_b.wdata = 8'h00;
      repeat (8) @(posedge clk);
      #1;
      {rst, bus_b.bus_reset} = 2'b00;
      idle(1);
      chk_defaults();
      chk("mute", bus_b.amp_mute, 0);
      rd_b("unmapped", 4'h1, 8'h00, 8'hFF);
      // four reads of the id register
      wr_b(PORT_MIX_ADDR, MIX_ID_REG);
      rd_b("id0", PORT_MIX_DATA, ID_BYTE0, 8'hFF);
      rd_b("id1", PORT_MIX_DATA, ID_BYTE1, 8'hFF);
      rd_b("id2", PORT_MIX_DATA, {4'h0, CFG_BASE[11:8]}, 8'hFF);
      rd_b("id3", PORT_MIX_DATA, CFG_BASE[7:0], 8'hFF);
      // every mode and time base choice
      for (int i = 0; i < 4; i++) begin
         wr_b(PORT_MODE, 8'(i));
         idle(2);
         chk("ext mode", ext, i & 1);
         chk("fifo", flen, i[0] ? EXT_FIFO_LEN : COMPAT_FIFO_LEN);
         chk("time base", tbase, bases[i]);
      end
      // dirty state, then soft reset with a mode write meanwhile
      mix = 8'($random(seed)) | 8'h01;
      wr_b(PORT_MIX_ADDR, 8'h10);
      wr_b(PORT_MIX_DATA, mix);
      wr_b(PORT_MODE, 8'h03);
      {voice_on, adc_dir} = 2'b11;
      idle(1);
      {voice_on, adc_dir} = 2'b00;
      idle(2);
      chk("voice on", von, 1);
      chk("adc dir set", adir, 1);
      wr_b(PORT_RESET, 8'h01);
      wr_b(PORT_MODE, 8'h01);
      idle(2);
      chk("ext held", ext, 0);
      wr_b(PORT_RESET, 8'h00);
      idle(2);
      chk_defaults();
      rd_b("mixer kept", PORT_MIX_DATA, mix, 8'hFF);
      // hardware reset also clears the mixer
      idle(2);
      bus_b.bus_reset = 1'b1;
      idle(2);
      bus_b.bus_reset = 1'b0;
      idle(1);
      chk_defaults();
      wr_b(PORT_MIX_ADDR, 8'h10);
      rd_b("mixer cleared", PORT_MIX_DATA, MIX_DEFAULT, 8'hFF);
      // mute rises only after the settle delay, drops at once
      for (int i = 0; i < 2; i++) begin
         wr_b(PORT_MUTE_CTL, 8'h01);
         idle(MUTE_TB - 1);
         chk("mute early", bus_b.amp_mute, 0);
         idle(2);
         chk("mute up", bus_b.amp_mute, 1);
         wr_b(PORT_MUTE_CTL, 8'h03);
         idle(2);
         chk("mute down", bus_b.amp_mute, 0);
      end
      wr_b(PORT_MUTE_CTL, 8'h01);
      idle(MUTE_TB + 4);
      bus_b.bus_reset = 1'b1;
      idle(1);
      bus_b.bus_reset = 1'b0;
      idle(1);
      chk("mute reset", bus_b.amp_mute, 0);
      // joined pair: two soft reset handshakes in a row
      for (int i = 0; i < 2; i++) begin
         hq.push_back(2'b10);
         idle(1 + ($random(seed) & 3));
         start = 1'b1;
         idle(1);
         start = 1'b0;
         idle(2);
         cnt = 0;
         while (busy !== 1'b0 && cnt < 600) begin
            idle(1);
            cnt++;
         end
         chk("host idle", busy, 0);
      end
      idle(4);
      chk("host answers left", hq.size(), 0);
      chk("reads left", rq.size(), 0);
      report_and_stop();
   end
endmodule : audio_reset_mode_control_tb
